// File: hw/lacr_consts.svh
// Purpose: constants for the load adaptive current regulator
// Assumes: included by bare name
// Notes:   widths and encodings only, no logic
`ifndef LACR_CONSTS_SVH
`define LACR_CONSTS_SVH
`define LACR_PERIOD_W       20
`define LACR_CUR_W          5
`define LACR_LOAD_W         10
`define LACR_STEP_W         2
`define LACR_DCNT_W         5
`define LACR_CUR_MAX        5'h1F
`define LACR_DEC_N0         5'h1F
`define LACR_DEC_N1         5'h07
`define LACR_DEC_N2         5'h01
`define LACR_DEC_N3         5'h00
`define LACR_FILT_DIV       2'h3
`define LACR_RESET_UPPER    20'h00000
`define LACR_RESET_LOWER    20'h00000
`endif

// File: hw/lacr_pkg.sv
// Purpose: shared types of the load adaptive current regulator
// Assumes: lacr_consts.svh present
// Notes:   types only
`include "lacr_consts.svh"
package lacr_pkg;
  typedef logic [`LACR_PERIOD_W-1:0] lacr_period_t;
  typedef logic [`LACR_CUR_W-1:0]    lacr_cur_t;
  typedef logic [`LACR_LOAD_W-1:0]   lacr_load_t;
  typedef enum logic [1:0] {
    LACR_IDLE,
    LACR_ACTIVE
  } lacr_state_t;
endpackage : lacr_pkg

// File: hw/lacr_window.sv
// Purpose: velocity window decode from measured step period
// Assumes: period grows as velocity falls
// Notes:   registered outputs
`timescale 1ns/1ps
`default_nettype none
module lacr_window (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire lacr_pkg::lacr_period_t measured_step_period,
  input  wire lacr_pkg::lacr_period_t regulation_low_period_threshold,
  input  wire lacr_pkg::lacr_period_t upper_period_threshold,
  output logic                      in_window,
  output logic                      above_upper
);
  import lacr_pkg::*;
  logic in_window_d;
  logic above_upper_d;
  always_comb begin
    // velocity at or above low limit means period not longer than threshold
    above_upper_d = (measured_step_period <= upper_period_threshold);
    in_window_d   = (measured_step_period <= regulation_low_period_threshold)
                    && !above_upper_d;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_window   <= 1'b0;
      above_upper <= 1'b0;
    end else begin
      in_window   <= in_window_d;
      above_upper <= above_upper_d;
    end
  end
endmodule : lacr_window
`default_nettype wire

// File: hw/lacr_filter.sv
// Purpose: measurement strobe thinning for the load filter
// Assumes: load_valid is a one-cycle pulse per measurement
// Notes:   passes every fourth strobe when enabled
`timescale 1ns/1ps
`default_nettype none
`include "lacr_consts.svh"
module lacr_filter (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic filter_en,
  input  wire logic load_valid,
  output logic      meas_strobe
);
  import lacr_pkg::*;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       strobe_d;
  always_comb begin
    cnt_d    = cnt_q;
    strobe_d = 1'b0;
    if (load_valid) begin
      if (!filter_en || cnt_q == `LACR_FILT_DIV) begin
        strobe_d = 1'b1;
        cnt_d    = 2'h0;
      end else begin
        cnt_d = cnt_q + 2'h1;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q       <= 2'h0;
      meas_strobe <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      meas_strobe <= strobe_d;
    end
  end
endmodule : lacr_filter
`default_nettype wire

// File: hw/lacr_top.sv
// Purpose: load adaptive motor current scale regulation
// Assumes: load results and step period synchronous to mclk
// Notes:   current scale code n means (n+1)/32 of full current
`timescale 1ns/1ps
`default_nettype none
`include "lacr_consts.svh"
module lacr_top (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire lacr_pkg::lacr_period_t measured_step_period,
  input  wire lacr_pkg::lacr_period_t regulation_low_period_threshold,
  input  wire lacr_pkg::lacr_period_t upper_period_threshold,
  input  wire lacr_pkg::lacr_load_t   load_result,
  input  wire lacr_pkg::lacr_load_t   alt_load_result,
  input  wire logic                   load_valid,
  input  wire logic                   silent_chopper,
  input  wire logic                   filter_en,
  input  wire lacr_pkg::lacr_load_t   lower_load_threshold,
  input  wire lacr_pkg::lacr_load_t   upper_load_threshold,
  input  wire logic [1:0]             current_increment_step,
  input  wire logic [1:0]             decrement_speed,
  input  wire logic                   min_current_quarter,
  input  wire lacr_pkg::lacr_cur_t    run_current,
  input  wire lacr_pkg::lacr_cur_t    hold_current,
  input  wire logic                   standstill,
  output lacr_pkg::lacr_cur_t         actual_current,
  output lacr_pkg::lacr_cur_t         applied_current,
  output logic                        full_step_mode,
  output logic                        regulation_active
);
  import lacr_pkg::*;

  logic        in_window;
  logic        above_upper;
  logic        meas_strobe;
  lacr_state_t state_q;
  lacr_state_t state_d;
  lacr_cur_t   cur_q;
  lacr_cur_t   cur_d;
  logic [`LACR_DCNT_W-1:0] dcnt_q;
  logic [`LACR_DCNT_W-1:0] dcnt_d;
  lacr_cur_t   applied_d;
  logic        full_d;
  lacr_cur_t   floor_v;
  lacr_load_t  load_v;
  logic [`LACR_CUR_W+2:0] up_sum;
  logic [2:0]  inc_v;
  lacr_load_t  load_q;
  lacr_load_t  load_d;
  logic [1:0]  vcnt_q;
  logic [1:0]  vcnt_d;

  lacr_window u_window (
    .mclk                            (mclk),
    .rst                             (rst),
    .measured_step_period            (measured_step_period),
    .regulation_low_period_threshold (regulation_low_period_threshold),
    .upper_period_threshold          (upper_period_threshold),
    .in_window                       (in_window),
    .above_upper                     (above_upper)
  );

  lacr_filter u_filter (
    .mclk        (mclk),
    .rst         (rst),
    .filter_en   (filter_en),
    .load_valid  (load_valid),
    .meas_strobe (meas_strobe)
  );

  // measurement count needed per decrement, minus one
  function automatic logic [`LACR_DCNT_W-1:0] dec_limit(
    input logic [1:0] code
  );
    case (code)
      2'h0:    dec_limit = `LACR_DEC_N0;
      2'h1:    dec_limit = `LACR_DEC_N1;
      2'h2:    dec_limit = `LACR_DEC_N2;
      default: dec_limit = `LACR_DEC_N3;
    endcase
  endfunction : dec_limit

  // floor of regulation; ceiling is run current itself
  function automatic lacr_cur_t cur_floor(
    input lacr_cur_t run,
    input logic      quarter
  );
    cur_floor = quarter ? (run >> 2) : (run >> 1);
  endfunction : cur_floor

  always_comb begin
    state_d   = state_q;
    cur_d     = cur_q;
    dcnt_d    = dcnt_q;
    floor_v   = cur_floor(run_current, min_current_quarter);
    // hold the reading of its strobe; the inputs move on meanwhile
    load_d    = load_valid ? (silent_chopper ? alt_load_result : load_result)
                           : load_q;
    load_v    = load_q;
    // zero increment code still moves by one step
    inc_v     = {1'b0, current_increment_step} + 3'h1;
    up_sum    = {3'h0, cur_q} + {5'h00, inc_v};
    case (state_q)
      LACR_IDLE: begin
        cur_d  = run_current;
        dcnt_d = '0;
        if (in_window) begin
          state_d = LACR_ACTIVE;
        end
      end
      LACR_ACTIVE: begin
        if (!in_window) begin
          state_d = LACR_IDLE;
          cur_d   = run_current;
          dcnt_d  = '0;
        end else begin
          if (meas_strobe) begin
            if (load_v < lower_load_threshold) begin
              // step up, saturate at run current
              if (up_sum >= {3'h0, run_current}) begin
                cur_d = run_current;
              end else begin
                cur_d = up_sum[`LACR_CUR_W-1:0];
              end
              dcnt_d = '0;
            end else if (load_v > upper_load_threshold) begin
              if (dcnt_q >= dec_limit(decrement_speed)) begin
                dcnt_d = '0;
                if (cur_q > floor_v) begin
                  cur_d = cur_q - 5'h01;
                end
              end else begin
                dcnt_d = dcnt_q + 5'h01;
              end
            end
          end
          // run current lowered by software clamps at once
          if (cur_d > run_current) begin
            cur_d = run_current;
          end else if (cur_d < floor_v) begin
            cur_d = floor_v;
          end
        end
      end
      default: begin
        state_d = LACR_IDLE;
      end
    endcase
    if (state_q == LACR_ACTIVE) begin
      applied_d = cur_q;
    end else begin
      applied_d = standstill ? hold_current : run_current;
    end
    full_d = above_upper;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q           <= LACR_IDLE;
      cur_q             <= `LACR_CUR_MAX;
      dcnt_q            <= '0;
      load_q            <= '0;
      actual_current    <= `LACR_CUR_MAX;
      applied_current   <= `LACR_CUR_MAX;
      full_step_mode    <= 1'b0;
      regulation_active <= 1'b0;
    end else begin
      state_q           <= state_d;
      cur_q             <= cur_d;
      dcnt_q            <= dcnt_d;
      load_q            <= load_d;
      actual_current    <= applied_d;
      applied_current   <= applied_d;
      full_step_mode    <= full_d;
      regulation_active <= (state_d == LACR_ACTIVE);
    end
  end

  // checker-side count of filtered readings, wraps instead of comparing
  always_comb begin
    vcnt_d = vcnt_q;
    if (load_valid) begin
      vcnt_d = filter_en ? (vcnt_q + 2'h1) : 2'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vcnt_q <= 2'h0;
    end else begin
      vcnt_q <= vcnt_d;
    end
  end

  sequence s_high_meas;
    meas_strobe && in_window && (state_q == LACR_ACTIVE)
      && (load_v > upper_load_threshold) && (load_v >= lower_load_threshold);
  endsequence

  regulation_off_a : assert property (
    @(posedge mclk) disable iff (rst)
    (state_q == LACR_ACTIVE && !in_window) |=> !regulation_active)
    else $error("regulation stayed on outside velocity window");

  upper_full_a : assert property (
    @(posedge mclk) disable iff (rst)
    above_upper |=> full_step_mode)
    else $error("full step mode missing above upper threshold");

  scale_bounds_a : assert property (
    @(posedge mclk) disable iff (rst)
    (state_q == LACR_ACTIVE && in_window && $stable(run_current)
      && $stable(min_current_quarter))
      |=> (cur_q <= $past(run_current)) && (cur_q >= $past(floor_v)))
    else $error("regulated scale outside limits");

  low_load_up_a : assert property (
    @(posedge mclk) disable iff (rst)
    (meas_strobe && in_window && state_q == LACR_ACTIVE
      && load_v < lower_load_threshold && $stable(run_current)
      && cur_q < run_current) |=> (cur_q > $past(cur_q)))
    else $error("current not raised on low load");

  dec_fast_a : assert property (
    @(posedge mclk) disable iff (rst)
    (s_high_meas ##0 (decrement_speed == 2'h3 && cur_q > floor_v + 5'h01
      && $stable(run_current)))
      |=> (cur_q == $past(cur_q) - 5'h01) && (dcnt_q == '0))
    else $error("code three did not decrement each measurement");

  count_restart_a : assert property (
    @(posedge mclk) disable iff (rst)
    (meas_strobe && state_q == LACR_ACTIVE && in_window
      && load_v < lower_load_threshold) |=> (dcnt_q == '0))
    else $error("decrement count not restarted");

  idle_plain_a : assert property (
    @(posedge mclk) disable iff (rst)
    (state_q == LACR_IDLE && standstill) |=> (applied_current == $past(hold_current)))
    else $error("hold current not applied below window");

  status_match_a : assert property (
    @(posedge mclk) disable iff (rst)
    (state_q == LACR_ACTIVE) |=> (actual_current == $past(cur_q)))
    else $error("status does not show regulated scale");

  filter_quarter_a : assert property (
    @(posedge mclk) disable iff (rst)
    (load_valid && filter_en) |=> (meas_strobe == ($past(vcnt_q) == 2'h3)))
    else $error("filtered strobe not on every fourth reading");

  filter_bypass_a : assert property (
    @(posedge mclk) disable iff (rst)
    (load_valid && !filter_en) |=> meas_strobe)
    else $error("unfiltered reading lost");

  strobe_source_a : assert property (
    @(posedge mclk) disable iff (rst)
    !load_valid |=> !meas_strobe)
    else $error("strobe without a reading");

  dec_wait_a : assert property (
    @(posedge mclk) disable iff (rst)
    (s_high_meas ##0 (dcnt_q < dec_limit(decrement_speed)))
      |=> (dcnt_q == $past(dcnt_q) + 5'h01))
    else $error("high reading not counted toward decrement");

  load_pick_a : assert property (
    @(posedge mclk) disable iff (rst)
    load_valid |=> (load_v == ($past(silent_chopper) ? $past(alt_load_result)
                                : $past(load_result))))
    else $error("wrong load reading captured");

  upper_off_a : assert property (
    @(posedge mclk) disable iff (rst)
    above_upper |=> !regulation_active)
    else $error("regulation on above upper threshold");

  window_on_a : assert property (
    @(posedge mclk) disable iff (rst)
    (state_q == LACR_IDLE && in_window) |=> regulation_active)
    else $error("regulation not started inside window");

  idle_run_a : assert property (
    @(posedge mclk) disable iff (rst)
    (state_q == LACR_IDLE && !standstill)
      |=> (applied_current == $past(run_current)))
    else $error("run current not applied below window");

endmodule : lacr_top
`default_nettype wire

// File: test/lacr_load_src.sv
// Purpose: load detector model feeding measurement pulses
// Assumes: bench sets load thresholds 100 and 200
// Notes:   the unselected input carries the opposite reading
`timescale 1ns/1ps
`default_nettype none
module lacr_load_src (
  input  wire logic            mclk,
  output lacr_pkg::lacr_load_t load_result,
  output lacr_pkg::lacr_load_t alt_load_result,
  output logic                 load_valid
);
  import lacr_pkg::*;
  localparam lacr_load_t LO = 10'h032;
  localparam lacr_load_t HI = 10'h12C;
  initial begin
    load_valid      = 1'b0;
    load_result     = HI;
    alt_load_result = LO;
  end
  // back-to-back pulses, the tightest spacing the block accepts
  task automatic send(input logic hi, input int n, input logic alt);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      #2;
      load_valid      = 1'b1;
      load_result     = (hi ^ alt) ? HI : LO;
      alt_load_result = (hi ^ alt) ? LO : HI;
    end
    @(posedge mclk);
    #2;
    load_valid      = 1'b0;
    // stale readings must not look valid
    load_result     = ~load_result;
    alt_load_result = ~alt_load_result;
  endtask : send
endmodule : lacr_load_src
`default_nettype wire

// File: test/lacr_top_tb.sv
// Purpose: self-checking bench for the load adaptive current regulator
// Assumes: design and load model compiled first
// Notes:   ordinary cases in a table, edge cases written out after it
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[FAIL] %0t got %0h want %0h", $time, got, exp); \
    end \
  end
module lacr_top_tb;
  import lacr_pkg::*;
  typedef struct { int run, q, dec, inc, sil, h1, l, h2, exp; } lacr_row_t;
  logic         mclk, rst, silent_chopper, filter_en, standstill, quarter;
  logic         full_step_mode, regulation_active, load_valid;
  logic [1:0]   inc_step, dec_speed;
  lacr_period_t period;
  lacr_load_t   load_result, alt_load_result;
  lacr_cur_t    run_current, hold_current, actual_current, applied_current;
  int           err_total, n_compared;
  lacr_row_t    rows [13] = '{
    '{20,0,3,0,0,3,0,0,17}, '{20,0,2,0,1,5,0,0,18}, '{20,0,1,0,0,8,0,0,19},
    '{20,0,0,0,1,32,0,0,19}, '{20,0,0,0,0,31,0,0,20},
    '{20,0,3,0,0,15,0,0,10}, '{20,1,3,0,0,17,0,0,5},
    '{20,0,3,1,0,6,1,0,16}, '{20,0,3,3,1,6,2,0,20}, '{20,0,2,0,0,1,1,1,20},
    '{20,0,3,2,0,8,1,0,15}, '{20,0,3,0,1,2,1,0,19}, '{31,0,3,0,0,1,0,0,30}};

  lacr_top DUT (
    .mclk(mclk), .rst(rst), .measured_step_period(period),
    .regulation_low_period_threshold(20'h001F4),
    .upper_period_threshold(20'h00064),
    .load_result(load_result), .alt_load_result(alt_load_result),
    .load_valid(load_valid), .silent_chopper(silent_chopper),
    .filter_en(filter_en), .lower_load_threshold(10'h064),
    .upper_load_threshold(10'h0C8), .current_increment_step(inc_step),
    .decrement_speed(dec_speed), .min_current_quarter(quarter),
    .run_current(run_current), .hold_current(hold_current),
    .standstill(standstill), .actual_current(actual_current),
    .applied_current(applied_current), .full_step_mode(full_step_mode),
    .regulation_active(regulation_active));
  lacr_load_src SRC (.mclk(mclk), .load_result(load_result),
    .alt_load_result(alt_load_result), .load_valid(load_valid));

  always #12.5 mclk = ~mclk;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick

  // leave and re-enter the window; a low reading clears any stale count
  task automatic enter();
    period = 20'h003E8;
    tick(4);
    period = 20'h0012C;
    tick(4);
    SRC.send(1'b0, 1, silent_chopper);
    tick(4);
    `CHK(actual_current, run_current)
  endtask : enter

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    stop_test();
  end

  initial begin
    {mclk, silent_chopper, filter_en, standstill, quarter} = '0;
    {inc_step, dec_speed, err_total, n_compared} = '0;
    rst = 1'b1;
    period = 20'h003E8;
    run_current = 5'h14;
    hold_current = 5'h07;
    tick(8);
    `CHK(actual_current, 5'h1F)
    `CHK({full_step_mode, regulation_active}, 2'h0)
    rst = 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      run_current = rows[i].run[4:0];
      quarter = rows[i].q[0];
      dec_speed = rows[i].dec[1:0];
      inc_step = rows[i].inc[1:0];
      silent_chopper = rows[i].sil[0];
      enter();
      SRC.send(1'b1, rows[i].h1, silent_chopper);
      SRC.send(1'b0, rows[i].l, silent_chopper);
      SRC.send(1'b1, rows[i].h2, silent_chopper);
      tick(4);
      `CHK(actual_current, lacr_cur_t'(rows[i].exp))
      `CHK(applied_current, lacr_cur_t'(rows[i].exp))
      `CHK(regulation_active, 1'b1)
      $display("row %0d done", i);
    end
    run_current = 5'h14;
    dec_speed = 2'h3;
    period = 20'h001F5;
    tick(4);
    SRC.send(1'b1, 4, silent_chopper);
    tick(4);
    `CHK({regulation_active, applied_current}, {1'b0, 5'h14})
    standstill = 1'b1;
    tick(4);
    `CHK(applied_current, hold_current)
    standstill = 1'b0;
    // period equal to threshold, as when set to the top ramp speed
    period = 20'h001F4;
    tick(4);
    `CHK(regulation_active, 1'b1)
    period = 20'h00064;
    tick(4);
    `CHK({full_step_mode, regulation_active}, 2'h2)
    period = 20'h00065;
    tick(4);
    `CHK({full_step_mode, regulation_active}, 2'h1)
    $display("window test done");
    enter();
    filter_en = 1'b1;
    SRC.send(1'b1, 8, silent_chopper);
    tick(4);
    `CHK(actual_current, 5'h12)
    filter_en = 1'b0;
    rst = 1'b1;
    tick(1);
    `CHK({actual_current, regulation_active}, {5'h1F, 1'b0})
    rst = 1'b0;
    tick(1);
    `CHK({actual_current, regulation_active}, {5'h14, 1'b0})
    tick(2);
    `CHK({actual_current, regulation_active}, {5'h14, 1'b1})
    $display("filter and reset test done");
    stop_test();
  end
endmodule : lacr_top_tb
`default_nettype wire
